// ### pkg/sadc_pkg.sv
/*
 Shared constants and types for the successive-approximation converter sequencer.
 Assumes a single peripheral clock and a byte-wide register port.
*/
package sadc_pkg;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [15:0] RESULT_LO_ADDR = 16'hFF08;
    localparam logic [15:0] RESULT_HI_ADDR = 16'hFF09;
    localparam logic [15:0] MODE_ADDR = 16'hFF30;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [15:0] RESULT_RESET = 16'h0000;
    localparam logic [7:0] HIGH_BYTE_RESET = 8'h00;

    // ----------------------------------------
    // Mode register fields
    // ----------------------------------------
    localparam int RUN_BIT = 7;
    localparam int FREQ_MSB = 5;
    localparam int FREQ_LSB = 3;
    localparam int LEN_MSB = 2;
    localparam int LEN_LSB = 1;
    localparam int CMP_BIT = 0;
    localparam int RESULT_PAD = 6;

    // ----------------------------------------
    // Phase lengths in conversion-clock cycles
    // ----------------------------------------
    localparam logic [4:0] CLEAR_CYCLES = 5'h02;
    localparam logic [4:0] SAMPLE_SHORT = 5'h06;
    localparam logic [4:0] SAMPLE_LONG = 5'h18;
    localparam logic [4:0] XFER_CYCLES = 5'h02;
    localparam logic [1:0] LEN_LONG = 2'h1;
    localparam logic [3:0] DIV_W = 4'h4;

    typedef enum logic [2:0] {
        PH_IDLE = 3'b000,
        PH_CLEAR = 3'b001,
        PH_SAMPLE = 3'b010,
        PH_APPROX = 3'b011,
        PH_XFER = 3'b100
    } sadc_phase_t;

    typedef struct packed {
        logic write;
        logic read;
        logic [15:0] addr;
        logic [7:0] wdata;
    } sadc_bus_req_t;

    typedef struct packed {
        logic sample;
        logic comparator_on;
        logic [9:0] trial;
    } sadc_analog_t;

endpackage

// ### src/sadc_clkdiv.sv
/*
 Conversion clock divider: one-cycle enable every N peripheral clocks.
 Assumes the select code is stable while the converter runs.
*/
`timescale 1ns/1ps
module sadc_clkdiv (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // Control
    input wire logic i_run,
    input wire logic [2:0] i_freq_sel,
    // Enable out
    output logic o_tick
);
    typedef struct packed {
        logic [3:0] cnt;
        logic tick;
    } sadc_div_state_t;

    sadc_div_state_t s_q;
    sadc_div_state_t s_d;

    // Divide ratios 12, 8, 6, 4, 3, 2
    function automatic logic [3:0] div_last(input logic [2:0] sel);
        unique case (sel)
            3'h0: div_last = 4'hB;
            3'h1: div_last = 4'h7;
            3'h2: div_last = 4'h5;
            3'h3: div_last = 4'h3;
            3'h4: div_last = 4'h2;
            default: div_last = 4'h1;
        endcase
    endfunction

    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (!i_run) begin
            s_d.cnt = 4'h0;
        end else if (s_q.cnt >= div_last(i_freq_sel)) begin
            s_d.cnt = 4'h0;
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + 4'h1;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_tick = s_q.tick;
endmodule

// ### src/sadc_sequencer.sv
/*
 Sequencer for a 10-bit successive-approximation converter: mode register,
 four-phase conversion sequence and result registers.
 Assumes an external sample-hold, comparator and resistor string, and a CPU
 byte port that honours the wait output.
*/
`timescale 1ns/1ps
module sadc_sequencer #(
    parameter int RES_BITS = 10
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // CPU register port
    input wire logic i_bus_write,
    input wire logic i_bus_read,
    input wire logic [15:0] i_bus_addr,
    input wire logic [7:0] i_bus_wdata,
    output logic [7:0] o_bus_rdata,
    output logic o_bus_wait,
    output logic [15:0] o_conversion_result_word,
    output logic [7:0] o_conversion_result_high_byte,
    // Analog side
    input wire logic i_comparator_high,
    output logic o_sample,
    output logic o_comparator_power,
    output logic [RES_BITS-1:0] o_trial_code,
    // Events
    output logic o_conversion_done_irq
);
    if (RES_BITS != 10) begin
        $error("sadc_sequencer supports 10-bit resolution only");
    end

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] mode;
        sadc_pkg::sadc_phase_t phase;
        logic [4:0] cnt;
        logic [3:0] bit_idx;
        logic [9:0] approx;
        logic [15:0] result;
        logic [7:0] high_byte;
        logic irq;
        logic wait_s;
        logic [7:0] rdata;
        logic sample;
        logic cmp_on;
        logic [9:0] trial;
    } sadc_state_t;

    sadc_state_t s_q;
    sadc_state_t s_d;
    logic tick;
    logic run;
    logic bus_wr;
    logic [9:0] trial_code;

    assign run = s_q.mode[sadc_pkg::RUN_BIT];

    sadc_clkdiv u_div (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_run(run),
        .i_freq_sel(s_q.mode[sadc_pkg::FREQ_MSB:sadc_pkg::FREQ_LSB]),
        .o_tick(tick)
    );

    // Sampling length from the length field
    function automatic logic [4:0] sample_len(input logic [1:0] len);
        sample_len = (len == sadc_pkg::LEN_LONG) ? sadc_pkg::SAMPLE_LONG : sadc_pkg::SAMPLE_SHORT;
    endfunction

    // Register read mux
    function automatic logic [7:0] read_mux(input logic [15:0] addr, input sadc_state_t s);
        unique case (addr)
            sadc_pkg::RESULT_LO_ADDR: read_mux = s.result[7:0];
            sadc_pkg::RESULT_HI_ADDR: read_mux = s.result[15:8];
            sadc_pkg::MODE_ADDR: read_mux = s.mode;
            default: read_mux = 8'h00;
        endcase
    endfunction

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        s_d = s_q;
        bus_wr = i_bus_write && (i_bus_addr == sadc_pkg::MODE_ADDR) && !s_q.wait_s;
        trial_code = s_q.approx | (10'h200 >> s_q.bit_idx);
        s_d.irq = 1'b0;
        s_d.rdata = i_bus_read ? read_mux(i_bus_addr, s_q) : s_q.rdata;
        s_d.wait_s = bus_wr;
        if (bus_wr) begin
            s_d.mode = i_bus_wdata;
        end
        s_d.cmp_on = s_d.mode[sadc_pkg::CMP_BIT];
        if (!run) begin
            s_d.phase = sadc_pkg::PH_IDLE;
            s_d.cnt = 5'h00;
        end else if (tick) begin
            unique case (s_q.phase)
                sadc_pkg::PH_IDLE: begin
                    s_d.phase = sadc_pkg::PH_CLEAR;
                    s_d.cnt = 5'h00;
                end
                sadc_pkg::PH_CLEAR: begin
                    s_d.approx = 10'h000;
                    s_d.bit_idx = 4'h0;
                    s_d.cnt = s_q.cnt + 5'h01;
                    if (s_q.cnt == sadc_pkg::CLEAR_CYCLES - 5'h01) begin
                        s_d.phase = sadc_pkg::PH_SAMPLE;
                        s_d.cnt = 5'h00;
                    end
                end
                sadc_pkg::PH_SAMPLE: begin
                    s_d.cnt = s_q.cnt + 5'h01;
                    if (s_q.cnt == sample_len(s_q.mode[sadc_pkg::LEN_MSB:sadc_pkg::LEN_LSB]) - 5'h01) begin
                        s_d.phase = sadc_pkg::PH_APPROX;
                        s_d.cnt = 5'h00;
                    end
                end
                sadc_pkg::PH_APPROX: begin
                    // One comparison per conversion clock, spare clocks at the end
                    s_d.cnt = s_q.cnt + 5'h01;
                    if (s_q.bit_idx < 4'hA) begin
                        if (i_comparator_high) begin
                            s_d.approx = trial_code;
                        end
                        s_d.bit_idx = s_q.bit_idx + 4'h1;
                    end
                    if (s_q.cnt == 5'h0B) begin
                        s_d.phase = sadc_pkg::PH_XFER;
                        s_d.cnt = 5'h00;
                    end
                end
                sadc_pkg::PH_XFER: begin
                    s_d.cnt = s_q.cnt + 5'h01;
                    if (s_q.cnt == 5'h00) begin
                        s_d.result = {s_q.approx, {sadc_pkg::RESULT_PAD{1'b0}}};
                        s_d.high_byte = s_q.approx[9:2];
                        s_d.irq = 1'b1;
                    end
                    if (s_q.cnt == sadc_pkg::XFER_CYCLES - 5'h01) begin
                        s_d.phase = sadc_pkg::PH_CLEAR;
                        s_d.cnt = 5'h00;
                    end
                end
                default: begin
                    s_d.phase = sadc_pkg::PH_IDLE;
                end
            endcase
        end
        s_d.sample = run && (s_d.phase == sadc_pkg::PH_SAMPLE);
        s_d.trial = (s_d.phase == sadc_pkg::PH_APPROX && s_d.bit_idx < 4'hA) ?
            (s_d.approx | (10'h200 >> s_d.bit_idx)) : s_d.approx;
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            s_q <= '0;
            s_q.mode <= sadc_pkg::MODE_RESET;
            s_q.result <= sadc_pkg::RESULT_RESET;
            s_q.high_byte <= sadc_pkg::HIGH_BYTE_RESET;
            s_q.phase <= sadc_pkg::PH_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign o_bus_rdata = s_q.rdata;
    assign o_bus_wait = s_q.wait_s;
    assign o_conversion_result_word = s_q.result;
    assign o_conversion_result_high_byte = s_q.high_byte;
    assign o_sample = s_q.sample;
    assign o_comparator_power = s_q.cmp_on;
    assign o_trial_code = s_q.trial;
    assign o_conversion_done_irq = s_q.irq;
endmodule

// ### test/sadc_analog_model.sv
/*
 Far-side model: sample-hold, comparator and resistor string.
 Assumes the held level is set by the bench and stays put during a conversion.
*/
`timescale 1ns/1ps
module sadc_analog_model (
    // Clock
    input wire logic i_clk,
    // From sequencer
    input wire logic i_power,
    input wire logic [9:0] i_trial,
    // Held input level
    input wire logic [9:0] i_level,
    // To sequencer
    output logic o_high
);
    logic flip_q = 1'b0;
    always @(posedge i_clk) begin
        flip_q <= ~flip_q;
    end
    // Unpowered comparator gives no stable answer
    assign o_high = i_power ? (i_level >= i_trial) : flip_q;
endmodule

// ### test/sadc_checker.sv
/*
 Port checker for the converter sequencer.
 Assumes the register map of the shared package.
*/
`timescale 1ns/1ps
module sadc_checker #(
    parameter int RES_BITS = 10
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_bus_write,
    input wire logic i_bus_read,
    input wire logic [15:0] i_bus_addr,
    input wire logic [7:0] i_bus_wdata,
    input wire logic [7:0] o_bus_rdata,
    input wire logic o_bus_wait,
    input wire logic [15:0] o_conversion_result_word,
    input wire logic [7:0] o_conversion_result_high_byte,
    input wire logic i_comparator_high,
    input wire logic o_sample,
    input wire logic o_comparator_power,
    input wire logic [RES_BITS-1:0] o_trial_code,
    input wire logic o_conversion_done_irq
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    sequence s_mode_wr;
        i_bus_write && i_bus_addr == sadc_pkg::MODE_ADDR && !o_bus_wait;
    endsequence
    sequence s_stop;
        s_mode_wr ##0 !i_bus_wdata[sadc_pkg::RUN_BIT];
    endsequence
    property p_irq_pulse;
        o_conversion_done_irq |=> !o_conversion_done_irq;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("irq wider than one cycle");
    property p_wait_set;
        s_mode_wr |=> o_bus_wait;
    endproperty
    a_wait_set: assert property (p_wait_set) else $error("no wait after mode write");
    property p_wait_one;
        o_bus_wait |=> !o_bus_wait;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("wait too long");
    property p_power;
        s_mode_wr |=> o_comparator_power == $past(i_bus_wdata[0]);
    endproperty
    a_power: assert property (p_power) else $error("comparator power mismatch");
    property p_low_zero;
        o_conversion_result_word[5:0] == 6'h00;
    endproperty
    a_low_zero: assert property (p_low_zero) else $error("low result bits set");
    property p_high_byte;
        o_conversion_result_high_byte == o_conversion_result_word[15:8];
    endproperty
    a_high_byte: assert property (p_high_byte) else $error("high byte mismatch");
    property p_result_at_end;
        $changed(o_conversion_result_word) |-> o_conversion_done_irq;
    endproperty
    a_result_at_end: assert property (p_result_at_end) else $error("result moved off end");
    property p_msb_first;
        $fell(o_sample) |-> ##[0:30] o_trial_code == {1'b1, {(RES_BITS-1){1'b0}}};
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("first trial not msb");
    property p_stop_quiet;
        s_stop |-> ##3 (!o_sample && !o_conversion_done_irq) [*8];
    endproperty
    a_stop_quiet: assert property (p_stop_quiet) else $error("activity after stop");
endmodule
bind sadc_sequencer sadc_checker #(.RES_BITS(RES_BITS)) sadc_checker_inst (.*);

// ### test/testbench.sv
/*
 Self-checking bench for the converter sequencer.
 Assumes the analog model answers the trial code directly.
*/
`timescale 1ns/1ps
module testbench;
    logic i_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic i_bus_write = 1'b0;
    logic i_bus_read = 1'b0;
    logic [15:0] i_bus_addr = 16'h0000;
    logic [7:0] i_bus_wdata = 8'h00;
    logic [7:0] o_bus_rdata;
    logic o_bus_wait, o_sample, o_comparator_power, o_conversion_done_irq, cmp_high;
    logic [15:0] o_conversion_result_word;
    logic [7:0] o_conversion_result_high_byte;
    logic [9:0] o_trial_code;
    logic [9:0] level = 10'h000;
    int n_errors = 0;
    int check_count = 0;
    int cyc = 0;
    int divs[6] = '{12, 8, 6, 4, 3, 2};
    always #5 i_clk = ~i_clk;
    sadc_sequencer sadc_sequencer_inst (.i_clk(i_clk), .i_nrst(i_nrst), .i_bus_write(i_bus_write),
        .i_bus_read(i_bus_read), .i_bus_addr(i_bus_addr), .i_bus_wdata(i_bus_wdata), .o_bus_rdata(o_bus_rdata),
        .o_bus_wait(o_bus_wait), .o_conversion_result_word(o_conversion_result_word),
        .o_conversion_result_high_byte(o_conversion_result_high_byte), .i_comparator_high(cmp_high),
        .o_sample(o_sample), .o_comparator_power(o_comparator_power), .o_trial_code(o_trial_code),
        .o_conversion_done_irq(o_conversion_done_irq));
    sadc_analog_model sadc_analog_model_inst (.i_clk(i_clk), .i_power(o_comparator_power),
        .i_trial(o_trial_code), .i_level(level), .o_high(cmp_high));
    task automatic print_verdict();
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            print_verdict();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] d);
        @(negedge i_clk);
        i_bus_write = 1'b1;
        i_bus_addr = 16'hFF30;
        i_bus_wdata = d;
        @(negedge i_clk);
        i_bus_write = 1'b0;
        chk({15'h0000, o_bus_wait}, 16'h0001, "wait");
        @(negedge i_clk);
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(negedge i_clk);
        i_bus_read = 1'b1;
        i_bus_addr = a;
        @(negedge i_clk);
        i_bus_read = 1'b0;
        d = o_bus_rdata;
    endtask
    task automatic wait_irq(output int n);
        n = 0;
        do begin
            @(negedge i_clk);
            n++;
        end while (o_conversion_done_irq !== 1'b1 && n < 3000);
    endtask
    task automatic quiet();
        logic [15:0] r;
        int n;
        r = o_conversion_result_word;
        n = 0;
        repeat (300) begin
            @(negedge i_clk);
            if (o_conversion_done_irq !== 1'b0) n++;
        end
        chk(16'(n), 16'h0000, "irq while stopped");
        chk(o_conversion_result_word, r, "result moved");
    endtask
    task automatic t_reset();
        logic [7:0] d;
        rd(16'hFF30, d);
        chk({8'h00, d}, 16'h0000, "mode reset");
        rd(16'hFF08, d);
        chk({8'h00, d}, 16'h0000, "result low reset");
        rd(16'hFF09, d);
        chk({8'h00, d}, 16'h0000, "result high reset");
        chk({15'h0000, o_comparator_power}, 16'h0000, "power reset");
    endtask
    task automatic t_waiting();
        wr(8'h01);
        chk({15'h0000, o_comparator_power}, 16'h0001, "power on");
        quiet();
    endtask
    task automatic t_convert(input logic [2:0] f, input logic l, input int div);
        logic [7:0] hi, lo;
        int n;
        level = {f, l, 6'h2B};
        wr({1'b1, 1'b0, f, 1'b0, l, 1'b1});
        wait_irq(n);
        wait_irq(n);
        wr(8'h01);
        chk(16'(n), 16'(div * (l ? 40 : 22)), "period");
        rd(16'hFF09, hi);
        rd(16'hFF08, lo);
        chk({hi, lo}, {level, 6'h00}, "result bytes");
        chk({8'h00, o_conversion_result_high_byte}, {8'h00, level[9:2]}, "high byte");
        chk(o_conversion_result_word, {level, 6'h00}, "result word");
        quiet();
    endtask
    task automatic t_nocmp();
        int n;
        wr(8'h80);
        chk({15'h0000, o_comparator_power}, 16'h0000, "power off");
        wait_irq(n);
        chk({15'h0000, o_conversion_done_irq}, 16'h0001, "irq without comparator");
        wr(8'h00);
        quiet();
    endtask
    task automatic t_reset_mid();
        int n;
        wr(8'h81);
        wait_irq(n);
        chk({15'h0000, o_conversion_done_irq}, 16'h0001, "irq before reset");
        @(negedge i_clk);
        i_nrst = 1'b0;
        @(negedge i_clk);
        chk(o_conversion_result_word, 16'h0000, "result in reset");
        chk({15'h0000, o_comparator_power}, 16'h0000, "power in reset");
        repeat (9) @(negedge i_clk);
        i_nrst = 1'b1;
        t_reset();
    endtask
    initial begin
        repeat (10) @(negedge i_clk);
        i_nrst = 1'b1;
        t_reset();
        t_waiting();
        for (int f = 0; f < 6; f++) begin
            t_convert(3'(f), 1'b0, divs[f]);
        end
        t_convert(3'h0, 1'b1, 12);
        t_nocmp();
        t_reset_mid();
        print_verdict();
    end
endmodule
